// ### card_interrupt_request_logic.sv
// interrupt request, masking, acceptance and restart vector logic of the card
`timescale 1ns/1ps
`default_nettype none
module card_interrupt_request_logic
   import card_irq_pkg::*;
#(
   parameter int SLOW_CYC = TICK_SLOW_CYC,
   parameter int FAST_CYC = TICK_FAST_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic bus_reset_n_i,
   // sources
   input wire logic nmi_n_i,
   input wire logic int_n_i,
   input wire logic aux_int_n_i,
   input wire logic parallel_bit7_input_i,
   input wire logic receive_char_ready_i,
   input wire logic transmit_holding_empty_i,
   input wire logic chain_busy_i,
   // processor core sequencing
   input wire logic instr_end_i,
   input wire logic rdy_i,
   input wire logic hold_i,
   input wire logic enable_instruction_i,
   input wire logic disable_instruction_i,
   input wire logic nonmaskable_return_i,
   input wire logic mode_select_i,
   input wire logic [1:0] mode_code_i,
   // i/o port access
   input wire logic [7:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   // data bus during acknowledge
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_n_o,
   // results
   output logic cpu_int_n_o,
   output logic manager_int_o,
   output logic gate_o,
   output logic sinta_o,
   output logic nmi_ack_o,
   output logic int_ack_o,
   output logic jump_o,
   output logic [15:0] jump_addr_o
);

   function automatic logic [LEVEL_W-1:0] top_level(input logic [NUM_SOURCES-1:0] act);
      logic [LEVEL_W-1:0] lv;
      lv = IDLE_LEVEL;
      for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
         if (act[i]) begin
            lv = LEVEL_W'(i);
         end
      end
      return lv;
   endfunction

   function automatic logic [7:0] restart_opcode(input logic [LEVEL_W-1:0] lv);
      return RESTART_OPCODE_BASE | {2'b00, lv, 3'b000};
   endfunction

   // ---------------- timers ----------------
   logic [7:0] command_reg, command_next;
   logic [7:0] mask_reg, mask_next;
   logic [NUM_TIMERS-1:0] timer_load, timer_zero;

   always_comb begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
         timer_load[t] = io_wr_i && (io_addr_i == PORT_TIMER_BASE + 8'(t));
      end
   end

   interval_timer_bank #(
      .N(NUM_TIMERS),
      .SLOW_CYC(SLOW_CYC),
      .FAST_CYC(FAST_CYC)
   ) u_timers (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .fast_tick_i(command_reg[CMD_FAST_TICK_BIT]),
      .load_i(timer_load),
      .load_data_i(io_wdata_i),
      .zero_o(timer_zero)
   );

   // ---------------- request latches ----------------
   logic [NUM_SOURCES-1:0] req_reg, req_next, req_set, req_clr, active;
   logic nmi_n_d_reg, aux_n_d_reg, pb7_d_reg, nmi_latch_reg;
   logic nmi_n_d_next, aux_n_d_next, pb7_d_next, nmi_latch_next;
   logic pending;
   logic [LEVEL_W-1:0] level_now, level_reg, level_next;
   logic addr_read, supply_clear;
   logic [7:0] rdata_next;
   logic nmi_take, int_take, sample_point;

   always_comb begin
      active = req_reg & mask_reg;
      pending = |active;
      level_now = top_level(active);
      addr_read = io_rd_i && (io_addr_i == PORT_INT_ADDR);

      req_set = '0;
      req_set[LVL_TIMER1] = timer_zero[0];
      req_set[LVL_TIMER2] = timer_zero[1];
      req_set[LVL_TIMER3] = timer_zero[2];
      req_set[LVL_TIMER4] = timer_zero[3];
      req_set[LVL_AUX] = aux_n_d_reg && !aux_int_n_i;
      req_set[LVL_RECEIVE] = receive_char_ready_i;
      req_set[LVL_TRANSMIT] = transmit_holding_empty_i;
      req_set[LVL_EIGHTH] = command_reg[CMD_SELECT_BIT] ?
                            (!pb7_d_reg && parallel_bit7_input_i) : timer_zero[4];

      req_clr = '0;
      if (io_wr_i && io_addr_i == PORT_COMMAND && io_wdata_i[CMD_CLEAR_BIT]) begin
         req_clr = '1;
      end
      if (addr_read && pending) begin
         req_clr[level_now] = 1'b1;
      end
      if (supply_clear) begin
         req_clr[level_reg] = 1'b1;
      end
      // a new event in the clearing cycle survives
      req_next = (req_reg & ~req_clr) | req_set;

      nmi_n_d_next = nmi_n_i;
      aux_n_d_next = aux_int_n_i;
      pb7_d_next = parallel_bit7_input_i;
      nmi_latch_next = (nmi_latch_reg && !nmi_take) ||
                       (nmi_n_d_reg && !nmi_n_i);

      command_next = command_reg;
      mask_next = mask_reg;
      if (io_wr_i && io_addr_i == PORT_COMMAND) begin
         command_next = io_wdata_i;
      end
      if (io_wr_i && io_addr_i == PORT_MASK) begin
         mask_next = io_wdata_i;
      end

      rdata_next = io_rdata_o;
      if (io_rd_i) begin
         rdata_next = 8'h00;
         if (io_addr_i == PORT_STATUS) begin
            rdata_next[STAT_PENDING_BIT] = pending;
            rdata_next[STAT_RECEIVE_BIT] = req_reg[LVL_RECEIVE];
            rdata_next[STAT_TRANSMIT_BIT] = req_reg[LVL_TRANSMIT];
         end else if (io_addr_i == PORT_INT_ADDR) begin
            rdata_next = restart_opcode(level_now);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_reg <= '0;
         nmi_n_d_reg <= 1'b1;
         aux_n_d_reg <= 1'b1;
         pb7_d_reg <= 1'b0;
         nmi_latch_reg <= 1'b0;
         command_reg <= 8'h00;
         mask_reg <= 8'h00;
         io_rdata_o <= 8'h00;
      end else if (ce_i) begin
         req_reg <= req_next;
         nmi_n_d_reg <= nmi_n_d_next;
         aux_n_d_reg <= aux_n_d_next;
         pb7_d_reg <= pb7_d_next;
         nmi_latch_reg <= nmi_latch_next;
         command_reg <= command_next;
         mask_reg <= mask_next;
         io_rdata_o <= rdata_next;
      end
   end

   // ---------------- processor acceptance ----------------
   ack_state_t state_reg, state_next;
   logic gate_next, saved_gate_reg, saved_gate_next;
   logic [1:0] mode_reg, mode_next;
   logic supply_reg, supply_next;
   logic manager_int_next, cpu_int_n_next;
   logic sinta_next, nmi_ack_next, int_ack_next, jump_next, data_oe_n_next;
   logic [15:0] jump_addr_next;
   logic [7:0] data_next, opcode;

   always_comb begin
      manager_int_next = pending && !chain_busy_i;
      cpu_int_n_next = !(manager_int_o || !int_n_i);
      // halt keeps issuing instruction ends, so a halted core is still served
      sample_point = instr_end_i && rdy_i && !hold_i && state_reg == ACK_IDLE;
      nmi_take = sample_point && nmi_latch_reg;
      int_take = sample_point && !nmi_latch_reg && gate_o && !cpu_int_n_o;
      supply_clear = state_reg == ACK_FETCH && supply_reg;

      gate_next = gate_o;
      saved_gate_next = saved_gate_reg;
      mode_next = mode_reg;
      if (!bus_reset_n_i) begin
         gate_next = 1'b0;
         saved_gate_next = 1'b0;
         mode_next = MODE_FETCH_0;
      end else if (nmi_take) begin
         gate_next = 1'b0;
         saved_gate_next = gate_o;
      end else if (int_take || disable_instruction_i) begin
         gate_next = 1'b0;
         saved_gate_next = 1'b0;
      end else if (enable_instruction_i) begin
         gate_next = 1'b1;
         saved_gate_next = 1'b1;
      end else if (nonmaskable_return_i) begin
         gate_next = saved_gate_reg;
      end
      if (bus_reset_n_i && mode_select_i) begin
         mode_next = mode_code_i;
      end

      state_next = state_reg;
      level_next = level_reg;
      supply_next = supply_reg;
      data_next = data_o;
      data_oe_n_next = 1'b1;
      sinta_next = 1'b0;
      nmi_ack_next = nmi_take;
      int_ack_next = int_take;
      jump_next = 1'b0;
      jump_addr_next = jump_addr_o;
      opcode = supply_reg ? data_o : data_i;

      unique case (state_reg)
         ACK_IDLE: begin
            if (nmi_take) begin
               jump_next = 1'b1;
               jump_addr_next = NMI_TARGET;
            end else if (int_take && mode_reg == MODE_FETCH_0) begin
               // only the mode 0 fetch is handled here
               state_next = ACK_FETCH;
               sinta_next = 1'b1;
               level_next = level_now;
               supply_next = command_reg[CMD_VECTOR_BIT] && manager_int_o;
               data_next = restart_opcode(level_now);
               data_oe_n_next = !(command_reg[CMD_VECTOR_BIT] && manager_int_o);
            end
         end
         ACK_FETCH: begin
            // external sources read sinta and drive data_i themselves
            state_next = ACK_IDLE;
            jump_next = 1'b1;
            jump_addr_next = {8'h00, 2'b00,
                              opcode[RESTART_FIELD_LSB +: LEVEL_W], 3'b000};
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ACK_IDLE;
         gate_o <= 1'b0;
         saved_gate_reg <= 1'b0;
         mode_reg <= MODE_FETCH_0;
         level_reg <= IDLE_LEVEL;
         supply_reg <= 1'b0;
         manager_int_o <= 1'b0;
         cpu_int_n_o <= 1'b1;
         sinta_o <= 1'b0;
         nmi_ack_o <= 1'b0;
         int_ack_o <= 1'b0;
         jump_o <= 1'b0;
         jump_addr_o <= 16'h0000;
         data_o <= 8'h00;
         data_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         state_reg <= state_next;
         gate_o <= gate_next;
         saved_gate_reg <= saved_gate_next;
         mode_reg <= mode_next;
         level_reg <= level_next;
         supply_reg <= supply_next;
         manager_int_o <= manager_int_next;
         cpu_int_n_o <= cpu_int_n_next;
         sinta_o <= sinta_next;
         nmi_ack_o <= nmi_ack_next;
         int_ack_o <= int_ack_next;
         jump_o <= jump_next;
         jump_addr_o <= jump_addr_next;
         data_o <= data_next;
         data_oe_n_o <= data_oe_n_next;
      end
   end

endmodule
`default_nettype wire

// ### card_irq_pkg.sv
// constants shared by the card interrupt request logic and its timer bank
package card_irq_pkg;

   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_SLOW_NS = 64000;
   localparam int TICK_FAST_NS = 8000;
   localparam int TICK_SLOW_CYC = (TICK_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_FAST_CYC = (TICK_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_W = 12;

   localparam int NUM_SOURCES = 8;
   localparam int NUM_TIMERS = 5;
   localparam int LEVEL_W = 3;

   // i/o port addresses
   localparam logic [7:0] PORT_STATUS = 8'h00;
   localparam logic [7:0] PORT_COMMAND = 8'h02;
   localparam logic [7:0] PORT_MASK = 8'h03;
   localparam logic [7:0] PORT_INT_ADDR = 8'h03;
   localparam logic [7:0] PORT_TIMER_BASE = 8'h05;

   // command port bits
   localparam int CMD_CLEAR_BIT = 0;
   localparam int CMD_SELECT_BIT = 2;
   localparam int CMD_VECTOR_BIT = 3;
   localparam int CMD_FAST_TICK_BIT = 5;

   // status port bits
   localparam int STAT_PENDING_BIT = 5;
   localparam int STAT_RECEIVE_BIT = 6;
   localparam int STAT_TRANSMIT_BIT = 7;

   // priority levels of the managed sources, 0 highest
   localparam int LVL_TIMER1 = 0;
   localparam int LVL_TIMER2 = 1;
   localparam int LVL_AUX = 2;
   localparam int LVL_TIMER3 = 3;
   localparam int LVL_RECEIVE = 4;
   localparam int LVL_TRANSMIT = 5;
   localparam int LVL_TIMER4 = 6;
   localparam int LVL_EIGHTH = 7;
   localparam logic [LEVEL_W-1:0] IDLE_LEVEL = 3'h7;

   // restart call opcode is 11 lll 111, target address 00 lll 000
   localparam logic [7:0] RESTART_OPCODE_BASE = 8'hc7;
   localparam int RESTART_FIELD_LSB = 3;
   localparam logic [15:0] NMI_TARGET = 16'h0066;

   localparam logic [1:0] MODE_FETCH_0 = 2'h0;

   typedef enum logic [1:0] {
      ACK_IDLE,
      ACK_FETCH
   } ack_state_t;

endpackage

// ### interval_timer_bank.sv
// bank of down-counting interval timers sharing one free-running tick
`timescale 1ns/1ps
`default_nettype none
module interval_timer_bank
   import card_irq_pkg::*;
#(
   parameter int N = NUM_TIMERS,
   parameter int SLOW_CYC = TICK_SLOW_CYC,
   parameter int FAST_CYC = TICK_FAST_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic fast_tick_i,
   input wire logic [N-1:0] load_i,
   input wire logic [7:0] load_data_i,
   output logic [N-1:0] zero_o
);

   logic [TICK_W-1:0] presc_reg, presc_next;
   logic tick;

   // the prescaler never restarts on a load, so a reload done before the
   // next tick keeps the interval locked to the tick grid
   always_comb begin
      tick = (fast_tick_i && presc_reg >= TICK_W'(FAST_CYC - 1)) ||
             (presc_reg >= TICK_W'(SLOW_CYC - 1));
      presc_next = tick ? '0 : presc_reg + TICK_W'(1);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_reg <= '0;
      end else if (ce_i) begin
         presc_reg <= presc_next;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_timer
         logic [7:0] cnt_reg, cnt_next;
         logic run_reg, run_next;
         logic zero_reg, zero_next;

         always_comb begin
            cnt_next = cnt_reg;
            run_next = run_reg;
            zero_next = 1'b0;
            if (load_i[g]) begin
               cnt_next = load_data_i;
               run_next = 1'b1;
            end else if (run_reg && tick) begin
               if (cnt_reg <= 8'h01) begin
                  cnt_next = 8'h00;
                  run_next = 1'b0;
                  zero_next = 1'b1;
               end else begin
                  cnt_next = cnt_reg - 8'h01;
               end
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cnt_reg <= 8'h00;
               run_reg <= 1'b0;
               zero_reg <= 1'b0;
            end else if (ce_i) begin
               cnt_reg <= cnt_next;
               run_reg <= run_next;
               zero_reg <= zero_next;
            end
         end

         assign zero_o[g] = zero_reg;
      end
   endgenerate

endmodule
`default_nettype wire

// ### card_irq_asserts.sv
// port-level assertions for the card interrupt request logic
`timescale 1ns/1ps
`default_nettype none
module card_irq_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic bus_reset_n_i,
   input wire logic int_n_i,
   input wire logic chain_busy_i,
   input wire logic rdy_i,
   input wire logic hold_i,
   input wire logic enable_instruction_i,
   input wire logic disable_instruction_i,
   input wire logic nonmaskable_return_i,
   input wire logic cpu_int_n_o,
   input wire logic manager_int_o,
   input wire logic gate_o,
   input wire logic sinta_o,
   input wire logic nmi_ack_o,
   input wire logic int_ack_o,
   input wire logic jump_o,
   input wire logic [15:0] jump_addr_o,
   input wire logic [7:0] data_o,
   input wire logic data_oe_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [7:0] op_reg;
   always_ff @(posedge clk_i) begin
      op_reg <= data_o;
   end
   sequence s_ack_cycle;
      sinta_o && !gate_o && !nmi_ack_o;
   endsequence
   sequence s_jump_cycle;
      jump_o && data_oe_n_o && jump_addr_o[15:6] == 10'h000 && jump_addr_o[2:0] == 3'h0;
   endsequence
   chk_int_entry: assert property (int_ack_o |-> s_ack_cycle ##1 s_jump_cycle)
      else $error("maskable entry steps wrong");
   chk_nmi_entry: assert property (nmi_ack_o |-> jump_o && jump_addr_o == 16'h0066
      && !gate_o && !sinta_o && !int_ack_o)
      else $error("nonmaskable entry wrong");
   chk_gate_rise: assert property ($rose(gate_o) |->
      $past(enable_instruction_i) || $past(nonmaskable_return_i))
      else $error("gate set without enable");
   chk_gate_clear: assert property (ce_i && (disable_instruction_i || !bus_reset_n_i)
      && !enable_instruction_i && !nonmaskable_return_i |=> !gate_o)
      else $error("gate not cleared");
   chk_stall_blocks: assert property (ce_i && (hold_i || !rdy_i) |=> !nmi_ack_o && !int_ack_o)
      else $error("accepted while stalled");
   chk_chain_block: assert property (manager_int_o |-> !$past(chain_busy_i))
      else $error("request while chain busy");
   chk_int_pin: assert property (ce_i && (manager_int_o || !int_n_i) |=> !cpu_int_n_o)
      else $error("cpu request missing");
   chk_vector_drive: assert property (!data_oe_n_o |-> sinta_o && data_o[7:6] == 2'h3
      && data_o[2:0] == 3'h7 ##1 jump_o && jump_addr_o[5:3] == op_reg[5:3])
      else $error("supplied vector wrong");
endmodule
bind card_interrupt_request_logic card_irq_asserts chk_u (.clk_i, .rst_i, .ce_i, .bus_reset_n_i,
   .int_n_i, .chain_busy_i, .rdy_i, .hold_i, .enable_instruction_i, .disable_instruction_i,
   .nonmaskable_return_i, .cpu_int_n_o, .manager_int_o, .gate_o, .sinta_o, .nmi_ack_o,
   .int_ack_o, .jump_o, .jump_addr_o, .data_o, .data_oe_n_o);
`default_nettype wire

// ### backplane_int_source.sv
// backplane device: level request, restart opcode on acknowledge
`timescale 1ns/1ps
`default_nettype none
module backplane_int_source (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic sinta_i,
   input wire logic [2:0] vec_i,
   output logic int_n_o,
   output logic [7:0] data_o
);
   logic [7:0] last_reg = 8'h00;
   logic [7:0] op;
   initial int_n_o = 1'b1;
   assign op = 8'hc7 | {2'h0, vec_i, 3'h0};
   // released bus shows the inverse of the last byte so stale data cannot pass
   assign data_o = (sinta_i && !int_n_o) ? op : ~last_reg;
   always @(posedge clk_i) begin
      if (sinta_i && !int_n_o) begin
         int_n_o <= 1'b1;
         last_reg <= op;
      end else if (req_i) begin
         int_n_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### test_card_interrupt_request_logic.sv
// self-checking bench for the card interrupt request logic
`timescale 1ns/1ps
`default_nettype none
module test_card_interrupt_request_logic
   import card_irq_pkg::*;
();
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
   logic clk_i = 0, rst_i = 1, ce_i = 1, bus_reset_n_i = 1, nmi_n_i = 1, aux_int_n_i = 1;
   logic parallel_bit7_input_i = 0, receive_char_ready_i = 0, transmit_holding_empty_i = 0;
   logic chain_busy_i = 0, instr_end_i = 0, rdy_i = 1, hold_i = 0, enable_instruction_i = 0;
   logic disable_instruction_i = 0, nonmaskable_return_i = 0, mode_select_i = 0;
   logic io_wr_i = 0, io_rd_i = 0, req = 0;
   logic [1:0] mode_code_i = 2'h0;
   logic [2:0] vec = 3'h0;
   logic [7:0] io_addr_i = 8'h00, io_wdata_i = 8'h00, io_rdata_o, data_i, data_o;
   logic int_n_i, data_oe_n_o, cpu_int_n_o, manager_int_o, gate_o, sinta_o, nmi_ack_o;
   logic int_ack_o, jump_o;
   logic [15:0] jump_addr_o;
   int fails = 0, comparisons = 0, k;
   int lvl[5] = '{LVL_TIMER1, LVL_TIMER2, LVL_TIMER3, LVL_TIMER4, LVL_EIGHTH};
   // short prescaler counts keep the timer runs brief
   localparam int SIM_SLOW = 8;
   card_interrupt_request_logic #(.SLOW_CYC(SIM_SLOW), .FAST_CYC(4)) dut_u (.clk_i, .rst_i, .ce_i,
      .bus_reset_n_i, .nmi_n_i, .int_n_i, .aux_int_n_i, .parallel_bit7_input_i,
      .receive_char_ready_i, .transmit_holding_empty_i, .chain_busy_i, .instr_end_i, .rdy_i,
      .hold_i, .enable_instruction_i, .disable_instruction_i, .nonmaskable_return_i,
      .mode_select_i, .mode_code_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
      .data_i, .data_o, .data_oe_n_o, .cpu_int_n_o, .manager_int_o, .gate_o, .sinta_o,
      .nmi_ack_o, .int_ack_o, .jump_o, .jump_addr_o);
   backplane_int_source far_u (.clk_i, .req_i(req), .sinta_i(sinta_o), .vec_i(vec),
      .int_n_o(int_n_i), .data_o(data_i));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   function automatic logic [7:0] rst_op(input int l);
      return 8'hc7 | 8'(l * 8);
   endfunction
   task automatic cyc();
      @(posedge clk_i);
      #2;
   endtask
   task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
      cyc();
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = 1;
      cyc();
      io_wr_i = 0;
   endtask
   task automatic io_rd(input logic [7:0] a, input logic [7:0] e);
      cyc();
      io_addr_i = a;
      io_rd_i = 1;
      cyc();
      io_rd_i = 0;
      `CHK("io_rdata_o", e, io_rdata_o)
   endtask
   task automatic ser();
      cyc();
      receive_char_ready_i = 1;
      transmit_holding_empty_i = 1;
      cyc();
      receive_char_ready_i = 0;
      transmit_holding_empty_i = 0;
   endtask
   task automatic ei();
      cyc();
      enable_instruction_i = 1;
      cyc();
      enable_instruction_i = 0;
   endtask
   task automatic wait_pend();
      for (k = 0; k < 200 && manager_int_o !== 1'b1; k++) cyc();
      `CHK("manager_int_o", 1'b1, manager_int_o)
   endtask
   task automatic wait_cpu();
      for (k = 0; k < 20 && cpu_int_n_o !== 1'b0; k++) cyc();
      `CHK("cpu_int_n_o", 1'b0, cpu_int_n_o)
   endtask
   // one instruction end; checks acceptance, acknowledge and the jump that follows
   task automatic accept(input logic n, input logic i, input logic oe_n, input logic [15:0] a);
      cyc();
      instr_end_i = 1;
      cyc();
      instr_end_i = 0;
      `CHK("nmi_ack_o", n, nmi_ack_o)
      `CHK("int_ack_o", i, int_ack_o)
      `CHK("sinta_o", i, sinta_o)
      `CHK("data_oe_n_o", oe_n, data_oe_n_o)
      if (!oe_n) `CHK("data_o", 8'hc7 | a[7:0], data_o)
      if (i) cyc();
      if (n || i) begin
         `CHK("jump_o", 1'b1, jump_o)
         `CHK("jump_addr_o", a, jump_addr_o)
         `CHK("gate_o", 1'b0, gate_o)
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      fails++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      #2 rst_i = 0;
      `CHK("cpu_int_n_o", 1'b1, cpu_int_n_o)
      `CHK("gate_o", 1'b0, gate_o)
      io_rd(PORT_STATUS, 8'h00);
      $display("test reset done");
      io_wr(PORT_MASK, 8'hff);
      ser();
      io_rd(PORT_STATUS, 8'he0);
      io_rd(PORT_INT_ADDR, 8'he7);
      io_rd(PORT_INT_ADDR, 8'hef);
      io_rd(PORT_STATUS, 8'h00);
      $display("test serial done");
      io_wr(PORT_MASK, 8'h00);
      cyc();
      aux_int_n_i = 0;
      chain_busy_i = 1;
      cyc();
      aux_int_n_i = 1;
      io_rd(PORT_STATUS, 8'h00);
      io_wr(PORT_MASK, 8'h04);
      io_rd(PORT_STATUS, 8'h20);
      `CHK("manager_int_o", 1'b0, manager_int_o)
      chain_busy_i = 0;
      wait_pend();
      io_wr(PORT_COMMAND, 8'h08);
      ei();
      wait_cpu();
      accept(0, 1, 0, 16'h0010);
      io_rd(PORT_STATUS, 8'h00);
      $display("test vector supply done");
      io_wr(PORT_COMMAND, 8'h04);
      io_wr(PORT_MASK, 8'h80);
      cyc();
      parallel_bit7_input_i = 1;
      io_rd(PORT_STATUS, 8'h20);
      io_rd(PORT_INT_ADDR, 8'hff);
      parallel_bit7_input_i = 0;
      io_rd(PORT_STATUS, 8'h00);
      ser();
      io_wr(PORT_COMMAND, 8'h01);
      io_rd(PORT_STATUS, 8'h00);
      $display("test select and clear done");
      for (int t = 0; t < 5; t++) begin
         io_wr(PORT_MASK, 8'h01 << lvl[t]);
         io_wr(PORT_TIMER_BASE + 8'(t), 8'h02);
         repeat (6) cyc();
         `CHK("manager_int_o", 1'b0, manager_int_o)
         wait_pend();
         io_rd(PORT_INT_ADDR, rst_op(lvl[t]));
         // reload inside the tick that ended the interval: the next one is
         // exactly two ticks, less the four cycles spent on the read and load
         io_wr(PORT_TIMER_BASE + 8'(t), 8'h02);
         wait_pend();
         `CHK("reload_interval", 2 * SIM_SLOW - 4, k)
         io_rd(PORT_INT_ADDR, rst_op(lvl[t]));
      end
      $display("test timers done");
      io_wr(PORT_MASK, 8'h00);
      for (int v = 0; v < 8; v++) begin
         vec = 3'(v);
         cyc();
         req = 1;
         cyc();
         req = 0;
         ei();
         wait_cpu();
         accept(0, 1, 1, 16'(v * 8));
      end
      cyc();
      req = 1;
      cyc();
      req = 0;
      accept(0, 0, 1, 16'h0000);
      $display("test external vector done");
      ei();
      cyc();
      nmi_n_i = 0;
      hold_i = 1;
      accept(0, 0, 1, 16'h0000);
      hold_i = 0;
      rdy_i = 0;
      accept(0, 0, 1, 16'h0000);
      rdy_i = 1;
      nmi_n_i = 1;
      accept(1, 0, 1, 16'h0066);
      cyc();
      nonmaskable_return_i = 1;
      cyc();
      nonmaskable_return_i = 0;
      `CHK("gate_o", 1'b1, gate_o)
      accept(0, 1, 1, 16'h0038);
      ei();
      cyc();
      disable_instruction_i = 1;
      cyc();
      disable_instruction_i = 0;
      `CHK("gate_o", 1'b0, gate_o)
      ei();
      cyc();
      mode_select_i = 1;
      mode_code_i = 2'h1;
      cyc();
      mode_select_i = 0;
      bus_reset_n_i = 0;
      cyc();
      bus_reset_n_i = 1;
      `CHK("gate_o", 1'b0, gate_o)
      // bus reset must bring back the acknowledge-and-fetch mode
      cyc();
      req = 1;
      cyc();
      req = 0;
      ei();
      wait_cpu();
      accept(0, 1, 1, 16'h0038);
      $display("test nonmaskable done");
      end_of_test();
   end
endmodule
`default_nettype wire
